// >>> design/crd_defines.svh
// offsets, field positions, reset values and timing counts
`ifndef CRD_DEFINES_SVH
`define CRD_DEFINES_SVH
// =====================================
// apb register map (byte addresses)
`define CRD_OFS_CTRL 12'h000
`define CRD_OFS_STATUS 12'h004
`define CRD_OFS_DGRAM 12'h008
`define CRD_OFS_RESP 12'h00c
// ctrl fields
`define CRD_CTRL_LDI_LSB 0
`define CRD_CTRL_START_BIT 8
`define CRD_LDI_RESET 2'h0
// datagram fields
`define CRD_DG_SPACE_BIT 31
`define CRD_DG_HALF_BIT 30
`define CRD_DG_ADDR_MSB 30
`define CRD_DG_ADDR_LSB 25
`define CRD_DG_RW_BIT 24
`define CRD_DG_ODD_LSB 8
// control space addresses reached by datagram
`define CRD_CADDR_LDI 6'h00
`define CRD_CADDR_STATUS 6'h01
// memory geometry
`define CRD_MEM_WORDS 64
`define CRD_WORD_W 6
`define CRD_LUT_BASE 6'h20
// snapshot layout per motor
`define CRD_SIG_W 20
`define CRD_PH_A 6
`define CRD_FD_A 7
`define CRD_DAC_B 8
`define CRD_PH_B 14
`define CRD_FD_B 15
`define CRD_ZERO 16
`define CRD_ONE 17
`define CRD_DIR 18
`define CRD_STEP 19
// timing
`define CRD_CLK_NS 100
`define CRD_SCK_HALF_NS 800
`define CRD_SCK_HALF_CYC ((`CRD_SCK_HALF_NS + `CRD_CLK_NS - 1) / `CRD_CLK_NS)
`endif

// >>> design/crd_pkg.sv
// types shared by the configuration ram driver sequencer
package crd_pkg;
  // =====================================
  // sequencer states
  typedef enum logic [2:0] {
    CRD_IDLE,
    CRD_FETCH,
    CRD_LOW,
    CRD_HIGH,
    CRD_END
  } crd_state_t;
endpackage

// >>> design/crd_top.sv
// configuration ram, microstep table and driver chain datagram sequencer
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "crd_defines.svh"
module crd_top #(
  parameter int SCK_HALF = `CRD_SCK_HALF_CYC // cycles per sck half period
) (
  input wire logic clk_i, // 10 mhz system clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [11:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic [23:0] phase_i, // 8-bit phase per motor
  input wire logic [2:0] dir_i, // direction per motor
  input wire logic [2:0] step_i, // step per motor
  input wire logic [2:0] fd_a_i, // fast decay coil a
  input wire logic [2:0] fd_b_i, // fast decay coil b
  output logic drv_sck_o, // driver chain clock
  output logic drv_sdo_o, // driver chain data
  output logic drv_ncs_o, // driver chain select, low active
  output logic busy_o // datagram in progress
);
  import crd_pkg::*;

  // elaboration check: the half-period counter below is 16 bits wide
  if (SCK_HALF < 1 || SCK_HALF > 65536) begin : g_sck_half_check
    $error("SCK_HALF must lie between 1 and 65536");
  end

  // =====================================
  // storage
  // pairs {odd, even}; no reset, contents undefined after power-up
  logic [11:0] mem [0:`CRD_MEM_WORDS-1];
  logic [1:0] ldi_reg;
  logic pend_reg;
  logic [31:0] resp_reg;
  crd_state_t state_reg;
  logic [5:0] idx_reg;
  logic [1:0] pos_reg;
  logic [15:0] cnt_reg;
  // frozen copy of all three motors' signals for one datagram
  logic [3*`CRD_SIG_W-1:0] snap_reg;

  // one table entry, 64 words over the upper 32 addresses
  // reads garbage until the host has loaded the table after power-up
  function automatic logic [5:0] lut_word(input logic [5:0] i);
    logic [11:0] pair;
    pair = mem[`CRD_LUT_BASE | {1'b0, i[5:1]}];
    return i[0] ? pair[11:6] : pair[5:0];
  endfunction

  // amplitude and polarity for an 8-bit phase
  // only a quarter wave is stored; mirror and sign bit give the rest
  function automatic logic [6:0] wave(input logic [7:0] ph);
    logic [5:0] i;
    i = ph[6] ? (6'h3f - ph[5:0]) : ph[5:0]; // mirror odd quadrants
    return {ph[7], lut_word(i)};
  endfunction

  // live control signals of each motor
  logic [3*`CRD_SIG_W-1:0] live;
  always_comb begin
    logic [6:0] wa;
    logic [6:0] wb;
    wa = 7'h0;
    wb = 7'h0;
    live = '0;
    for (int m = 0; m < 3; m++) begin
      wa = wave(phase_i[m*8 +: 8]);
      wb = wave(phase_i[m*8 +: 8] + 8'h40); // 90 degree shift
      live[m*`CRD_SIG_W +: 6] = wa[5:0];
      live[m*`CRD_SIG_W + `CRD_PH_A] = wa[6];
      live[m*`CRD_SIG_W + `CRD_FD_A] = fd_a_i[m];
      live[m*`CRD_SIG_W + `CRD_DAC_B +: 6] = wb[5:0];
      live[m*`CRD_SIG_W + `CRD_PH_B] = wb[6];
      live[m*`CRD_SIG_W + `CRD_FD_B] = fd_b_i[m];
      live[m*`CRD_SIG_W + `CRD_ZERO] = 1'b0;
      live[m*`CRD_SIG_W + `CRD_ONE] = 1'b1;
      live[m*`CRD_SIG_W + `CRD_DIR] = dir_i[m];
      live[m*`CRD_SIG_W + `CRD_STEP] = step_i[m];
    end
  end

  // =====================================
  // apb slave, one wait state
  logic acc;
  logic done;
  logic [31:0] rd_val;
  logic map_ok;
  assign acc = psel_i & penable_i;
  assign done = acc & pready_o;

  // read decode; any other offset answers with an error
  always_comb begin
    map_ok = 1'b1;
    rd_val = 32'h0;
    case (paddr_i)
      `CRD_OFS_CTRL: rd_val = {30'h0, ldi_reg};
      `CRD_OFS_STATUS: rd_val = {29'h0, pos_reg, busy_o};
      `CRD_OFS_DGRAM: rd_val = resp_reg;
      `CRD_OFS_RESP: rd_val = resp_reg;
      default: map_ok = 1'b0;
    endcase
  end

  // ready rises one cycle into the access phase, drops after the edge
  // trade-off: a fixed wait state keeps the decode off the ready path
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~map_ok;
      prdata_o <= (acc & ~pready_o & ~pwrite_i) ? rd_val : 32'h0;
    end
  end

  // =====================================
  // datagram execution
  logic dg_wr;
  logic [31:0] dg;
  logic [5:0] dg_addr;
  logic [11:0] rd_pair;
  // the datagram is the write data of the committing beat
  assign dg = pwdata_i;
  assign dg_wr = done & pwrite_i & ~pslverr_o & (paddr_i == `CRD_OFS_DGRAM);
  assign dg_addr = dg[`CRD_DG_ADDR_MSB:`CRD_DG_ADDR_LSB];
  assign rd_pair = mem[dg_addr];

  // both words land in the same cycle, so no torn config word
  always_ff @(posedge clk_i) begin
    if (dg_wr && dg[`CRD_DG_SPACE_BIT] && !dg[`CRD_DG_RW_BIT]) begin
      mem[dg_addr] <= {dg[`CRD_DG_ODD_LSB +: 6], dg[5:0]};
    end
  end

  // read response: memory data in 24-bit field, rest zero
  // header byte is echoed so the host can match answer to request
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      resp_reg <= 32'h0;
    end else if (dg_wr && dg[`CRD_DG_RW_BIT]) begin
      if (dg[`CRD_DG_SPACE_BIT]) begin
        resp_reg <= {dg[31:24], 10'h0, rd_pair[11:6], 2'h0, rd_pair[5:0]};
      end else if (dg_addr == `CRD_CADDR_LDI) begin
        resp_reg <= {dg[31:24], 22'h0, ldi_reg};
      end else if (dg_addr == `CRD_CADDR_STATUS) begin
        resp_reg <= {dg[31:24], 21'h0, pos_reg, busy_o};
      end else begin
        resp_reg <= {dg[31:24], 24'h0};
      end
    end
  end

  // last driver index, by apb ctrl or control-space datagram
  // an apb write wins when both land in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ldi_reg <= `CRD_LDI_RESET;
    end else if (done && pwrite_i && paddr_i == `CRD_OFS_CTRL) begin
      ldi_reg <= pwdata_i[`CRD_CTRL_LDI_LSB +: 2];
    end else if (dg_wr && !dg[`CRD_DG_SPACE_BIT] && !dg[`CRD_DG_RW_BIT]
                 && dg_addr == `CRD_CADDR_LDI) begin
      ldi_reg <= dg[1:0];
    end
  end

  // start request held until the sequencer takes it; new request wins
  // a start while busy is kept and served once the sequencer is idle
  logic start_wr;
  logic take;
  assign start_wr = done & pwrite_i & (paddr_i == `CRD_OFS_CTRL)
                    & pwdata_i[`CRD_CTRL_START_BIT];
  assign take = (state_reg == CRD_IDLE) & pend_reg;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pend_reg <= 1'b0;
    end else if (start_wr) begin
      pend_reg <= 1'b1;
    end else if (take) begin
      pend_reg <= 1'b0;
    end
  end

  // =====================================
  // driver chain sequencer
  logic [11:0] cfg_pair;
  logic [5:0] cfg_word;
  logic flag;
  logic [4:0] code;
  logic sel_bit;
  // even word of a pair goes first, then the odd word
  assign cfg_pair = mem[{1'b0, idx_reg[5:1]}];
  assign cfg_word = idx_reg[0] ? cfg_pair[11:6] : cfg_pair[5:0];
  assign flag = cfg_word[5];
  assign code = cfg_word[4:0];
  // codes above the step code read as zero
  always_comb begin
    sel_bit = 1'b0;
    // position three has no motor behind it, so it sends zeros
    if (code < 5'(`CRD_SIG_W) && pos_reg != 2'h3) begin
      sel_bit = snap_reg[32'(pos_reg) * `CRD_SIG_W + 32'(code)];
    end
  end

  // one fetch per word; a data word then spends two sck halves
  // flag words send nothing and cost a single cycle each
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= CRD_IDLE;
      idx_reg <= 6'h0;
      pos_reg <= 2'h0;
      cnt_reg <= 16'h0;
      snap_reg <= '0;
      drv_sck_o <= 1'b0;
      drv_sdo_o <= 1'b0;
      drv_ncs_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      case (state_reg)
        CRD_IDLE: begin
          // select drops a full cycle before the first data bit
          if (pend_reg) begin
            snap_reg <= live;
            idx_reg <= 6'h0;
            pos_reg <= 2'h0;
            drv_ncs_o <= 1'b0;
            busy_o <= 1'b1;
            state_reg <= CRD_FETCH;
          end
        end
        CRD_FETCH: begin
          if (flag) begin
            idx_reg <= idx_reg + 6'h1;
            if (pos_reg == ldi_reg) begin
              state_reg <= CRD_END;
            end else begin
              pos_reg <= pos_reg + 2'h1;
            end
          end else begin
            // sdo changes only here and in CRD_END, in both cases while sck is low
            drv_sdo_o <= sel_bit;
            cnt_reg <= 16'h0;
            state_reg <= CRD_LOW;
          end
        end
        CRD_LOW: begin
          if (cnt_reg == 16'(SCK_HALF - 1)) begin
            cnt_reg <= 16'h0;
            drv_sck_o <= 1'b1;
            state_reg <= CRD_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        CRD_HIGH: begin
          if (cnt_reg == 16'(SCK_HALF - 1)) begin
            cnt_reg <= 16'h0;
            drv_sck_o <= 1'b0;
            idx_reg <= idx_reg + 6'h1; // wraps in config range
            state_reg <= CRD_FETCH;
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        CRD_END: begin
          // a changed last index acts only at the next flag word
          pos_reg <= 2'h0;
          idx_reg <= 6'h0;
          drv_ncs_o <= 1'b1;
          drv_sdo_o <= 1'b0;
          busy_o <= 1'b0;
          state_reg <= CRD_IDLE;
        end
        default: state_reg <= CRD_IDLE;
      endcase
    end
  end
endmodule

// >>> tb/crd_chain_rx.sv
// driver chain receiver model that collects the bits of one datagram
`timescale 1ns/1ps
module crd_chain_rx (
  input wire logic sck_i, // chain clock
  input wire logic sdo_i, // chain data
  input wire logic ncs_i, // chain select, low active
  output logic [31:0] bits_o, // received bits, last in lsb
  output int cnt_o // bits received in this datagram
);
  // =====================================
  // shift register, cleared at each new select
  initial begin
    bits_o = '0;
    cnt_o = 0;
  end
  always @(negedge ncs_i) begin
    bits_o = '0;
    cnt_o = 0;
  end
  // driver samples on the rising chain clock only while selected
  always @(posedge sck_i) begin
    if (!ncs_i) begin
      bits_o = {bits_o[30:0], sdo_i};
      cnt_o++;
    end
  end
endmodule

// >>> tb/crd_top_sva.sv
// port checker for the datagram sequencer
`timescale 1ns/1ps
module crd_top_sva #(
  parameter int SCK_HALF = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic drv_sck_o,
  input wire logic drv_sdo_o,
  input wire logic drv_ncs_o,
  input wire logic busy_o
);
  // =====================================
  // helper: length of the current sck high phase
  int hi_cnt;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !drv_sck_o) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_alone: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready or with data");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside ready");
  a_ncs_busy: assert property (drv_ncs_o == !busy_o)
    else $error("select and busy disagree");
  a_sck_idle: assert property (drv_ncs_o |-> !drv_sck_o && !drv_sdo_o)
    else $error("chain active while deselected");
  a_sdo_hold: assert property (drv_sck_o |-> $stable(drv_sdo_o))
    else $error("data moved while sck high");
  a_sck_high: assert property ($fell(drv_sck_o) |-> hi_cnt == SCK_HALF)
    else $error("sck high phase length wrong");
  a_start_busy: assert property (psel_i && penable_i && pready_o && pwrite_i &&
    paddr_i == 12'h000 && pwdata_i[8] && !busy_o |-> ##[1:4] busy_o)
    else $error("start did not begin datagram");
  c_start: cover property ($rose(busy_o));
  c_end: cover property ($fell(busy_o));
  c_err: cover property (pready_o && pslverr_o);
endmodule
bind crd_top crd_top_sva #(.SCK_HALF(SCK_HALF)) u_sva (.clk_i(clk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .drv_sck_o(drv_sck_o), .drv_sdo_o(drv_sdo_o), .drv_ncs_o(drv_ncs_o), .busy_o(busy_o));

// >>> tb/test_crd_top.sv
// self-checking bench for the datagram sequencer
`timescale 1ns/1ps
module test_crd_top;
  logic clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, e;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, rd, bits;
  logic prdy, perr, sck, sdo, ncs, busy;
  logic [2:0] dir = '0;
  logic [23:0] ph = '0;
  // config words 5..0,6,13..8,14 then a flag; two table entries
  logic [31:0] wav [10] = '{32'h80000405, 32'h82000203, 32'h84000001, 32'h86000d06,
    32'h88000b0c, 32'h8a00090a, 32'h8c000e08, 32'h8e000020, 32'hfa00002d, 32'hc4001600};
  int cnt, err_count = 0, n_compared = 0;
  // datagram write, datagram read, expected response
  logic [31:0] rows [4][3] = '{
    '{32'h80ffe1c5, 32'h81000000, 32'h81002105},
    '{32'hc0003f2a, 32'hc1000000, 32'hc1003f2a},
    '{32'hfe000a15, 32'hff000000, 32'hff000a15},
    '{32'h00000002, 32'h01000000, 32'h01000002}};
  always #50 clk_i = ~clk_i;
  // =====================================
  // design and chain receiver
  crd_top #(.SCK_HALF(2)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .phase_i(ph), .dir_i(dir), .step_i(3'h0), .fd_a_i(3'h0),
    .fd_b_i(3'h0), .drv_sck_o(sck), .drv_sdo_o(sdo), .drv_ncs_o(ncs), .busy_o(busy));
  crd_chain_rx rx (.sck_i(sck), .sdo_i(sdo), .ncs_i(ncs), .bits_o(bits), .cnt_o(cnt));
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // one apb transfer; an idle edge after release avoids re-driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (prdy !== 1'b1) begin
      err_count++;
      close_out();
    end
    rd = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk_i);
  endtask
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 3000 && busy !== v; k++) @(posedge clk_i);
    if (busy !== v) begin
      err_count++;
      close_out();
    end
  endtask
  // =====================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    chk("reset_outs", 32'h0, {26'h0, prdy, perr, sck, sdo, busy, ~ncs});
    nrst_i <= 1;
    @(posedge clk_i);
    apb(0, 12'h000, 32'h0);
    chk("ldi_reset", 32'h0, rd);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h008, rows[i][0]);
      apb(1, 12'h008, rows[i][1]);
      apb(0, 12'h00c, 32'h0);
      chk("resp", rows[i][2], rd);
    end
    $display("test rows done");
    apb(0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], e});
    // memory set up before any start: one, zero, one, flag
    apb(1, 12'h008, 32'h80001011);
    apb(1, 12'h008, 32'h82002011);
    apb(1, 12'h000, 32'h00000100);
    wait_busy(1);
    wait_busy(0);
    chk("bits_one", 32'h5, bits);
    chk("cnt_one", 32'h3, 32'(cnt));
    apb(0, 12'h004, 32'h0);
    chk("status", 32'h0, rd);
    $display("test single driver done");
    // second driver sends its direction bit after the first flag
    dir <= 3'b010;
    apb(1, 12'h008, 32'h84002012);
    apb(1, 12'h000, 32'h00000101);
    wait_busy(1);
    dir <= 3'b000;
    apb(1, 12'h008, 32'h81000000);
    apb(0, 12'h00c, 32'h0);
    chk("resp_busy", 32'h81001011, rd);
    wait_busy(0);
    chk("bits_two", 32'hb, bits);
    chk("cnt_two", 32'h4, 32'(cnt));
    $display("test two drivers done");
    // coil a from the mirrored quadrant, coil b a quarter turn on
    ph <= 24'h000045;
    for (int i = 0; i < 10; i++) apb(1, 12'h008, wav[i]);
    apb(1, 12'h000, 32'h00000100);
    wait_busy(1);
    wait_busy(0);
    chk("bits_wave", 32'h2d2d, bits);
    chk("cnt_wave", 32'he, 32'(cnt));
    $display("test wave done");
    // reset in mid-datagram: outputs idle, last index back to zero
    apb(1, 12'h000, 32'h00000100);
    wait_busy(1);
    apb(1, 12'h008, 32'h00000003);
    apb(0, 12'h000, 32'h0);
    chk("ldi_dg", 32'h3, rd);
    chk("busy_pre", 32'h1, {31'h0, busy});
    nrst_i <= 0;
    repeat (3) @(posedge clk_i);
    chk("reset_mid", 32'h0, {26'h0, prdy, perr, sck, sdo, busy, ~ncs});
    nrst_i <= 1;
    @(posedge clk_i);
    apb(0, 12'h000, 32'h0);
    chk("ldi_mid", 32'h0, rd);
    apb(0, 12'h004, 32'h0);
    chk("status_mid", 32'h0, rd);
    $display("test mid reset done");
    close_out();
  end
endmodule
